// *** src/iosd_regs.svh ***
/*
 * Constants of the I/O slot decoder and process image block: addresses,
 * fixed slot map, system behaviour word layout and time-out figures.
 * Assumes it is included by bare name; definitions only.
 */
`ifndef IOSD_REGS_SVH
`define IOSD_REGS_SVH

`define IOSD_SYSW_ADDR 16'heaf0
`define IOSD_SYSW_RST 16'h0000
`define IOSD_SYSW_IN_INH 1
`define IOSD_SYSW_OUT_INH 2
`define IOSD_P_PAGE 8'hf0
`define IOSD_IMG_PAGE 8'hef
`define IOSD_CC_SLOTS 7
`define IOSD_ANA_SLOTS 4
`define IOSD_DIG_SIZE 4
`define IOSD_EXP_BASE 28
`define IOSD_ANA_BASE 128
`define IOSD_ANA_SIZE 32
`define IOSD_CLK_NS 40
`define IOSD_TMO_NS 100000
`define IOSD_TMO_CYC (`IOSD_TMO_NS / `IOSD_CLK_NS)

`endif

// *** src/iosd_pkg.sv ***
/*
 * Types of the I/O slot decoder and process image block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package iosd_pkg;
    typedef enum logic [1:0] {
        IOSD_IDLE,
        IOSD_DEC,
        IOSD_WAIT
    } iosd_state_t;
endpackage

// *** src/iosd_top.sv ***
/*
 * I/O slot decoder with process input and output images, the system
 * behaviour word, direct module access and bus time-out stop.
 * Assumes a single 25 MHz clock, inputs synchronous to it, and switch and
 * slot configuration inputs that stay static while the controller runs.
 */
// Operation
// - Fixed digital slot gets four consecutive bytes, 32 channels.
// - Small digital modules answer on the lowest bytes of their block.
// - Fixed analog decoding exists only for central slots 0 to 3.
// - Each fixed analog slot spans 32 bytes, 16 word channels.
// - 8-channel analog module uses the lowest 16 bytes of its block.
// - Central digital slots at bytes 0..27, analog at 128..255.
// - Expansion digital slots at bytes 28..63, no analog decoding.
// - Variable mode: slot base byte comes from its own switches.
// - Variable mode: input and output slots may share an address.
// - Type switch OFF: 32 digital/16 analog; ON: 16 digital/8 analog.
// - Seven switches weigh 128 down to 2 and give channel 0 byte.
// - Scan start copies inputs into the input image for the scan.
// - Behaviour word bit 1 set skips the input image update.
// - Output image goes to output modules at scan end.
// - Behaviour word bit 2 set skips the output transfer.
// - Programmer writes to the behaviour word only when stopped.
// - Analog and direct digital access bypass the images.
// - Direct access to an empty slot times out and stops.
`timescale 1ns/1ns
`include "iosd_regs.svh"

module iosd_top
    import iosd_pkg::*;
#(
    parameter int NSLOT = 16,
    parameter int NBYTE = 128,
    parameter int TMO_CYC = `IOSD_TMO_CYC
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic acc_req_i,
    input wire logic acc_we_i,
    input wire logic acc_word_i,
    input wire logic [15:0] acc_addr_i,
    input wire logic [15:0] acc_wdata_i,
    output logic acc_ack_o,
    output logic acc_err_o,
    output logic [15:0] acc_rdata_o,
    input wire logic prog_wr_i,
    input wire logic [15:0] prog_wdata_i,
    input wire logic run_i,
    output logic prog_refused_o,
    input wire logic scan_start_i,
    input wire logic scan_end_i,
    output logic scan_busy_o,
    input wire logic var_mode_i,
    input wire logic [NSLOT-1:0] slot_out_i,
    input wire logic [NSLOT-1:0] slot_analog_i,
    input wire logic [NSLOT-1:0] slot_used_i,
    input wire logic [NSLOT-1:0] sw_type_i,
    input wire logic [NSLOT*7-1:0] sw_addr_i,
    output logic [NSLOT-1:0] mod_sel_o,
    output logic [4:0] mod_off_o,
    output logic mod_rd_o,
    output logic mod_wr_o,
    output logic [7:0] mod_wdata_o,
    input wire logic [7:0] mod_rdata_i,
    input wire logic mod_ack_i,
    output logic bus_timeout_stop_o,
    output logic [7:0] tmo_addr_o,
    output logic [15:0] sysw_o
);
    localparam int TW = $clog2(TMO_CYC + 1);

    iosd_state_t state_q;
    logic [7:0] cur_addr_q;
    logic cur_out_q;
    logic scan_in_q;
    logic scan_out_q;
    logic word_q;
    logic phase_q;
    logic [15:0] wdata_q;
    logic [TW-1:0] tmo_q;
    logic [15:0] sysw_q;
    logic [7:0] in_img [NBYTE];
    logic [7:0] out_img [NBYTE];
    logic [NSLOT-1:0] hit_v;
    logic [NSLOT-1:0] ana_v;
    logic [4:0] off_v [NSLOT];
    logic [NSLOT-1:0] pick;
    logic [4:0] pick_off;
    logic pick_ana;
    logic pick_used;
    logic scanning;
    logic is_p, is_img, is_sys;
    logic [6:0] ia;
    logic [6:0] ib;
    logic acc_go;
    logic mod_done;
    logic tmo_hit;

    assign scanning = scan_in_q | scan_out_q;
    assign is_p = acc_addr_i[15:8] == `IOSD_P_PAGE;
    assign is_img = acc_addr_i[15:8] == `IOSD_IMG_PAGE;
    assign is_sys = acc_addr_i[15:1] == `IOSD_SYSW_ADDR >> 1;
    assign ia = acc_addr_i[6:0];
    assign ib = ia + 7'h01;
    assign acc_go = state_q == IOSD_IDLE && !scan_start_i && !scan_end_i
        && acc_req_i;
    assign mod_done = state_q == IOSD_WAIT && mod_ack_i && |mod_sel_o;
    assign tmo_hit = state_q == IOSD_WAIT && !mod_done
        && tmo_q == TW'(TMO_CYC - 1);

    // Base and size of each slot, compared against the current byte
    for (genvar i = 0; i < NSLOT; i++) begin : g_slot
        logic [8:0] base;
        logic [8:0] size;
        logic ana;
        always_comb begin
            if (var_mode_i) begin
                base = {1'b0, sw_addr_i[i*7 +: 7], 1'b0};
                ana = sw_addr_i[i*7+6];
                if (ana) begin
                    size = sw_type_i[i] ? 9'h010 : 9'h020;
                end else begin
                    size = sw_type_i[i] ? 9'h002 : 9'h004;
                end
            end else if (slot_analog_i[i]) begin
                ana = 1'b1;
                if (i < `IOSD_ANA_SLOTS) begin
                    base = 9'(`IOSD_ANA_BASE + `IOSD_ANA_SIZE * i);
                    size = 9'(`IOSD_ANA_SIZE);
                end else begin
                    // No analog decoding outside central slots 0 to 3
                    base = 9'h000;
                    size = 9'h000;
                end
            end else begin
                ana = 1'b0;
                size = 9'(`IOSD_DIG_SIZE);
                if (i < `IOSD_CC_SLOTS) begin
                    base = 9'(`IOSD_DIG_SIZE * i);
                end else begin
                    base = 9'(`IOSD_EXP_BASE
                        + `IOSD_DIG_SIZE * (i - `IOSD_CC_SLOTS));
                end
            end
        end
        // Direction is part of the match, so in and out may overlap
        assign hit_v[i] = {1'b0, cur_addr_q} >= base
            && {1'b0, cur_addr_q} < base + size
            && slot_out_i[i] == cur_out_q;
        assign off_v[i] = 5'({1'b0, cur_addr_q} - base);
        assign ana_v[i] = ana;
    end

    // Lowest slot wins, so a misset switch never yields two selects
    always_comb begin
        pick = '0;
        pick_off = 5'h00;
        pick_ana = 1'b0;
        pick_used = 1'b0;
        for (int k = NSLOT - 1; k >= 0; k--) begin
            if (hit_v[k]) begin
                pick = '0;
                pick[k] = 1'b1;
                pick_off = off_v[k];
                pick_ana = ana_v[k];
                pick_used = slot_used_i[k];
            end
        end
    end

    // System behaviour word
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sysw_q <= `IOSD_SYSW_RST;
            prog_refused_o <= 1'b0;
        end else begin
            prog_refused_o <= prog_wr_i && run_i;
            if (prog_wr_i && !run_i) begin
                sysw_q <= prog_wdata_i;
            end else if (acc_go && acc_we_i && is_sys) begin
                if (acc_word_i) begin
                    sysw_q <= acc_wdata_i;
                end else if (acc_addr_i[0]) begin
                    sysw_q[7:0] <= acc_wdata_i[7:0];
                end else begin
                    sysw_q[15:8] <= acc_wdata_i[7:0];
                end
            end
        end
    end
    assign sysw_o = sysw_q;

    // Image storage, no reset so it maps to memory
    always_ff @(posedge clk_i) begin
        if (mod_done && scan_in_q) begin
            in_img[cur_addr_q[6:0]] <= mod_rdata_i;
        end
        if (acc_go && acc_we_i && is_img) begin
            if (acc_word_i) begin
                if (acc_addr_i[7]) begin
                    out_img[ia] <= acc_wdata_i[15:8];
                    out_img[ib] <= acc_wdata_i[7:0];
                end else begin
                    in_img[ia] <= acc_wdata_i[15:8];
                    in_img[ib] <= acc_wdata_i[7:0];
                end
            end else if (acc_addr_i[7]) begin
                out_img[ia] <= acc_wdata_i[7:0];
            end else begin
                in_img[ia] <= acc_wdata_i[7:0];
            end
        end
    end

    // Sequencer for direct access and image transfers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= IOSD_IDLE;
            cur_addr_q <= 8'h00;
            cur_out_q <= 1'b0;
            scan_in_q <= 1'b0;
            scan_out_q <= 1'b0;
            word_q <= 1'b0;
            phase_q <= 1'b0;
            wdata_q <= 16'h0000;
            tmo_q <= '0;
            acc_ack_o <= 1'b0;
            acc_err_o <= 1'b0;
            acc_rdata_o <= 16'h0000;
            mod_sel_o <= '0;
            mod_off_o <= 5'h00;
            mod_rd_o <= 1'b0;
            mod_wr_o <= 1'b0;
            mod_wdata_o <= 8'h00;
            bus_timeout_stop_o <= 1'b0;
            tmo_addr_o <= 8'h00;
            scan_busy_o <= 1'b0;
        end else begin
            acc_ack_o <= 1'b0;
            acc_err_o <= 1'b0;
            case (state_q)
                IOSD_IDLE: begin
                    tmo_q <= '0;
                    phase_q <= 1'b0;
                    if (scan_start_i) begin
                        if (!sysw_q[`IOSD_SYSW_IN_INH]) begin
                            scan_in_q <= 1'b1;
                            scan_busy_o <= 1'b1;
                            cur_addr_q <= 8'h00;
                            cur_out_q <= 1'b0;
                            state_q <= IOSD_DEC;
                        end
                    end else if (scan_end_i) begin
                        if (!sysw_q[`IOSD_SYSW_OUT_INH]) begin
                            scan_out_q <= 1'b1;
                            scan_busy_o <= 1'b1;
                            cur_addr_q <= 8'h00;
                            cur_out_q <= 1'b1;
                            state_q <= IOSD_DEC;
                        end
                    end else if (acc_req_i) begin
                        if (is_p) begin
                            if (bus_timeout_stop_o) begin
                                // Stopped: no direct module access until reset, scans still run
                                acc_ack_o <= 1'b1;
                                acc_err_o <= 1'b1;
                            end else begin
                                cur_addr_q <= acc_addr_i[7:0];
                                cur_out_q <= acc_we_i;
                                word_q <= acc_word_i;
                                wdata_q <= acc_wdata_i;
                                state_q <= IOSD_DEC;
                            end
                        end else begin
                            acc_ack_o <= 1'b1;
                            if (acc_we_i) begin
                                acc_rdata_o <= 16'h0000;
                            end else if (is_sys) begin
                                acc_rdata_o <= acc_word_i ? sysw_q
                                    : {8'h00, acc_addr_i[0] ? sysw_q[7:0]
                                    : sysw_q[15:8]};
                            end else if (is_img && acc_addr_i[7]) begin
                                acc_rdata_o <= acc_word_i
                                    ? {out_img[ia], out_img[ib]}
                                    : {8'h00, out_img[ia]};
                            end else if (is_img) begin
                                acc_rdata_o <= acc_word_i
                                    ? {in_img[ia], in_img[ib]}
                                    : {8'h00, in_img[ia]};
                            end else begin
                                acc_rdata_o <= 16'h0000;
                            end
                        end
                    end
                end
                IOSD_DEC: begin
                    tmo_q <= '0;
                    if (scanning) begin
                        // Image walk covers configured digital slots only
                        if (|pick && pick_used && !pick_ana) begin
                            mod_sel_o <= pick;
                            mod_off_o <= pick_off;
                            mod_rd_o <= scan_in_q;
                            mod_wr_o <= scan_out_q;
                            mod_wdata_o <= out_img[cur_addr_q[6:0]];
                            state_q <= IOSD_WAIT;
                        end else if (cur_addr_q == 8'(NBYTE - 1)) begin
                            scan_in_q <= 1'b0;
                            scan_out_q <= 1'b0;
                            scan_busy_o <= 1'b0;
                            state_q <= IOSD_IDLE;
                        end else begin
                            cur_addr_q <= cur_addr_q + 8'h01;
                        end
                    end else begin
                        // A miss still waits, so an empty slot times out
                        mod_sel_o <= pick;
                        mod_off_o <= pick_off;
                        mod_rd_o <= !cur_out_q;
                        mod_wr_o <= cur_out_q;
                        mod_wdata_o <= (word_q && !phase_q)
                            ? wdata_q[15:8] : wdata_q[7:0];
                        state_q <= IOSD_WAIT;
                    end
                end
                IOSD_WAIT: begin
                    tmo_q <= tmo_q + TW'(1);
                    if (mod_done) begin
                        mod_sel_o <= '0;
                        mod_rd_o <= 1'b0;
                        mod_wr_o <= 1'b0;
                        if (scanning) begin
                            if (cur_addr_q == 8'(NBYTE - 1)) begin
                                scan_in_q <= 1'b0;
                                scan_out_q <= 1'b0;
                                scan_busy_o <= 1'b0;
                                state_q <= IOSD_IDLE;
                            end else begin
                                cur_addr_q <= cur_addr_q + 8'h01;
                                state_q <= IOSD_DEC;
                            end
                        end else if (word_q && !phase_q) begin
                            // High byte first at the channel address
                            acc_rdata_o[15:8] <= mod_rdata_i;
                            phase_q <= 1'b1;
                            cur_addr_q <= cur_addr_q + 8'h01;
                            state_q <= IOSD_DEC;
                        end else begin
                            if (word_q) begin
                                acc_rdata_o[7:0] <= mod_rdata_i;
                            end else begin
                                acc_rdata_o <= {8'h00, mod_rdata_i};
                            end
                            acc_ack_o <= 1'b1;
                            state_q <= IOSD_IDLE;
                        end
                    end else if (tmo_hit) begin
                        mod_sel_o <= '0;
                        mod_rd_o <= 1'b0;
                        mod_wr_o <= 1'b0;
                        bus_timeout_stop_o <= 1'b1;
                        tmo_addr_o <= cur_addr_q;
                        acc_ack_o <= !scanning;
                        acc_err_o <= !scanning;
                        scan_in_q <= 1'b0;
                        scan_out_q <= 1'b0;
                        scan_busy_o <= 1'b0;
                        state_q <= IOSD_IDLE;
                    end
                end
                default: begin
                    state_q <= IOSD_IDLE;
                end
            endcase
        end
    end

endmodule

// *** bench/iosd_top_assertions.sv ***
/* Checker for the I/O slot decoder, bound to iosd_top.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ns
module iosd_chk #(
    parameter int NSLOT = 16,
    parameter int TMO_CYC = 8
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic acc_ack_o,
    input wire logic acc_err_o,
    input wire logic prog_wr_i,
    input wire logic [15:0] prog_wdata_i,
    input wire logic run_i,
    input wire logic prog_refused_o,
    input wire logic scan_busy_o,
    input wire logic [NSLOT-1:0] mod_sel_o,
    input wire logic [4:0] mod_off_o,
    input wire logic mod_rd_o,
    input wire logic mod_wr_o,
    input wire logic mod_ack_i,
    input wire logic bus_timeout_stop_o,
    input wire logic [15:0] sysw_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    logic stb;
    int cnt_q;
    assign stb = mod_rd_o || mod_wr_o;
    // Length of the current module cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= 0;
        end else begin
            cnt_q <= stb ? cnt_q + 1 : 0;
        end
    end
    a_sel_onehot: assert property ($onehot0(mod_sel_o))
        else $error("more than one slot selected");
    a_ack_pulse: assert property (acc_ack_o |=> !acc_ack_o)
        else $error("access answer longer than one cycle");
    a_err_ack: assert property (acc_err_o |-> acc_ack_o)
        else $error("error without answer");
    a_prog_refuse: assert property (prog_wr_i && run_i |=> prog_refused_o)
        else $error("run mode write not refused");
    a_prog_write: assert property (prog_wr_i && !run_i |=>
        sysw_o == $past(prog_wdata_i))
        else $error("stop mode write lost");
    a_refuse_cause: assert property (prog_refused_o |->
        $past(prog_wr_i && run_i))
        else $error("refusal without cause");
    a_stop_sticky: assert property (bus_timeout_stop_o |=> bus_timeout_stop_o)
        else $error("stop flag cleared");
    a_strobe_drop: assert property (stb && |mod_sel_o && mod_ack_i |=> !stb)
        else $error("strobe held after answer");
    a_sel_hold: assert property (stb && !mod_ack_i |=>
        !stb || ($stable(mod_sel_o) && $stable(mod_off_o)))
        else $error("select moved during module cycle");
    a_tmo_limit: assert property (cnt_q <= TMO_CYC + 1)
        else $error("module cycle outlived time-out");
    c_scan: cover property ($rose(scan_busy_o));
    c_stop: cover property ($rose(bus_timeout_stop_o));
    c_refuse: cover property (prog_refused_o);
    c_write: cover property (mod_wr_o && mod_ack_i);
endmodule

bind iosd_top iosd_chk #(.NSLOT(NSLOT), .TMO_CYC(TMO_CYC)) iosd_chk_i (
    .clk_i, .arst_n_i, .acc_ack_o, .acc_err_o, .prog_wr_i, .prog_wdata_i,
    .run_i, .prog_refused_o, .scan_busy_o, .mod_sel_o, .mod_off_o, .mod_rd_o,
    .mod_wr_o, .mod_ack_i, .bus_timeout_stop_o, .sysw_o);

// *** bench/iosd_mods.sv ***
/* Model of the plug-in I/O modules: a byte store per slot answering
   the strobes at once or after three cycles.
   Assumes one-hot selects and strobes held until the answer. */
`timescale 1ns/1ns
module iosd_mods (
    input wire logic clk_i,
    input wire logic [15:0] sel_i,
    input wire logic [4:0] off_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic slow_i,
    output logic [7:0] rdata_o,
    output logic ack_o
);
    logic [7:0] mem [16][32];
    int wait_q = 0;
    int s;
    initial begin
        ack_o = 1'b0;
        rdata_o = 8'h00;
    end
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        // Off the answer cycle data flips, so stale bytes never match
        rdata_o <= ~rdata_o;
        s = 0;
        for (int i = 0; i < 16; i++) if (sel_i[i]) s = i;
        // No decode hit means nobody answers
        if ((rd_i || wr_i) && |sel_i && !ack_o) begin
            if (wait_q < (slow_i ? 3 : 0)) begin
                wait_q <= wait_q + 1;
            end else begin
                wait_q <= 0;
                ack_o <= 1'b1;
                rdata_o <= mem[s][off_i];
                if (wr_i) mem[s][off_i] <= wdata_i;
            end
        end
    end
endmodule

// *** bench/iosd_top_tb_top.sv ***
/* Self-checking bench: random and corner accesses, image walks,
   behaviour word and time-out. Assumes the model in iosd_mods.sv. */
`timescale 1ns/1ns
module iosd_top_tb_top;
    logic clk_i = 0, arst_n_i = 0, acc_req_i = 0, acc_we_i = 0;
    logic acc_word_i = 0, prog_wr_i = 0, run_i = 1, scan_start_i = 0;
    logic scan_end_i = 0, var_mode_i = 0, slow = 0, er;
    logic [15:0] acc_addr_i = '0, acc_wdata_i = '0, prog_wdata_i = '0;
    logic [15:0] slot_out_i = 16'hff00, slot_analog_i = 16'h0003;
    logic [15:0] slot_used_i = 16'hfffc, sw_type_i = '0;
    logic [111:0] sw_addr_i = '0;
    logic acc_ack_o, acc_err_o, prog_refused_o, scan_busy_o, mod_rd_o;
    logic mod_wr_o, mod_ack_i, bus_timeout_stop_o;
    logic [15:0] acc_rdata_o, mod_sel_o, sysw_o, rd;
    logic [4:0] mod_off_o;
    logic [7:0] mod_wdata_o, mod_rdata_i, tmo_addr_o, v;
    int n_fail = 0, num_checks = 0, s, o, b;
    always #20 clk_i = ~clk_i;
    iosd_top #(.TMO_CYC(8)) iosd_top_i (.clk_i, .arst_n_i, .acc_req_i,
        .acc_we_i, .acc_word_i, .acc_addr_i, .acc_wdata_i, .acc_ack_o,
        .acc_err_o, .acc_rdata_o, .prog_wr_i, .prog_wdata_i, .run_i,
        .prog_refused_o, .scan_start_i, .scan_end_i, .scan_busy_o,
        .var_mode_i, .slot_out_i, .slot_analog_i, .slot_used_i, .sw_type_i,
        .sw_addr_i, .mod_sel_o, .mod_off_o, .mod_rd_o, .mod_wr_o,
        .mod_wdata_o, .mod_rdata_i, .mod_ack_i, .bus_timeout_stop_o,
        .tmo_addr_o, .sysw_o);
    iosd_mods iosd_mods_i (.clk_i, .sel_i(mod_sel_o), .off_i(mod_off_o),
        .rd_i(mod_rd_o), .wr_i(mod_wr_o), .wdata_i(mod_wdata_o),
        .slow_i(slow), .rdata_o(mod_rdata_i), .ack_o(mod_ack_i));
    function automatic logic [7:0] pat(int s, int o);
        return 8'(s * 32 + o) ^ 8'h3c;
    endfunction
    task automatic print_verdict;
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rst(input int n);
        arst_n_i = 0;
        repeat (n) @(negedge clk_i);
        arst_n_i = 1;
        @(negedge clk_i);
    endtask
    task automatic acc(input logic we, wd, input logic [15:0] a, d);
        int n;
        @(negedge clk_i);
        {acc_req_i, acc_we_i, acc_word_i, acc_addr_i} = {1'b1, we, wd, a};
        acc_wdata_i = d;
        @(negedge clk_i);
        acc_req_i = 0;
        for (n = 0; acc_ack_o !== 1'b1 && n < 300; n++) @(negedge clk_i);
        if (n == 300) n_fail++;
        rd = acc_rdata_o;
        er = acc_err_o;
    endtask
    task automatic scan(input logic st);
        int n;
        @(negedge clk_i);
        {scan_start_i, scan_end_i} = {st, !st};
        @(negedge clk_i);
        {scan_start_i, scan_end_i} = 2'b00;
        for (n = 0; scan_busy_o === 1'b1 && n < 5000; n++) @(negedge clk_i);
        if (n == 5000) n_fail++;
    endtask
    task automatic prog(input logic [15:0] d);
        @(negedge clk_i);
        {prog_wr_i, prog_wdata_i} = {1'b1, d};
        @(negedge clk_i);
        prog_wr_i = 0;
    endtask
    initial begin
        #2000000;
        n_fail++;
        print_verdict;
    end
    initial begin
        void'($urandom(81685));
        for (s = 0; s < 16; s++) for (o = 0; o < 32; o++)
            iosd_mods_i.mem[s][o] = pat(s, o);
        rst(16);
        chk("sysw reset", '0, sysw_o);
        repeat (30) begin
            s = $urandom_range(15, 0);
            slow = $urandom;
            o = $urandom_range(3, 0);
            b = s < 7 ? 4 * s : 28 + 4 * (s - 7);
            if (s < 2) begin
                o = 2 * $urandom_range(7, 0);
                acc(0, 1, 16'hf080 + 16'(32 * s + o), '0);
                chk("analog", {pat(s, o), pat(s, o + 1)}, rd);
            end else if (s < 8) begin
                acc(0, 0, 16'hf000 + 16'(b + o), '0);
                chk("digital", {8'h00, pat(s, o)}, rd);
            end else begin
                v = $urandom;
                acc(1, 0, 16'hf000 + 16'(b + o), {8'h00, v});
                chk("out", v, iosd_mods_i.mem[s][o]);
            end
        end
        // Central slot 2 holds a digital module, so no analog decode
        acc(0, 0, 16'hf0c0, '0);
        chk("tmo err", 1, er);
        chk("stop", 1, bus_timeout_stop_o);
        chk("tmo addr", 16'h00c0, tmo_addr_o);
        acc(0, 0, 16'hf008, '0);
        chk("stopped err", 1, er);
        rst(2);
        scan(1);
        for (b = 8; b < 32; b++) begin
            acc(0, 0, 16'hef00 + 16'(b), '0);
            chk("in image", {8'h00, pat(b / 4, b % 4)}, rd);
        end
        iosd_mods_i.mem[3][1] = ~pat(3, 1);
        acc(0, 0, 16'hef0d, '0);
        chk("snapshot", {8'h00, pat(3, 1)}, rd);
        acc(1, 1, 16'heaf0, 16'h0002);
        scan(1);
        acc(0, 0, 16'hef0d, '0);
        chk("in inhibit", {8'h00, pat(3, 1)}, rd);
        acc(1, 1, 16'heaf0, '0);
        scan(1);
        acc(0, 0, 16'hef0d, '0);
        chk("in update", {8'h00, ~pat(3, 1)}, rd);
        v = $urandom;
        acc(1, 0, 16'hefa1, {8'h00, v});
        scan(0);
        chk("out xfer", v, iosd_mods_i.mem[8][1]);
        acc(1, 1, 16'heaf0, 16'h0004);
        acc(1, 0, 16'hefa1, {8'h00, ~v});
        scan(0);
        chk("out inhibit", v, iosd_mods_i.mem[8][1]);
        prog(16'h0002);
        chk("refused", 1, prog_refused_o);
        chk("kept", 16'h0004, sysw_o);
        run_i = 0;
        prog(16'h0000);
        chk("prog write", '0, sysw_o);
        run_i = 1;
        // Output walk copied unwritten image bytes into the output slots
        for (s = 0; s < 16; s++) for (o = 0; o < 32; o++)
            iosd_mods_i.mem[s][o] = pat(s, o);
        var_mode_i = 1;
        slot_out_i = 16'h3f00;
        sw_type_i = (16'($urandom) & 16'h00ff) | 16'h8000;
        for (s = 0; s < 13; s++) sw_addr_i[s * 7 +: 7] = 7'(2 * s);
        sw_addr_i[13 * 7 +: 7] = 7'h00;
        sw_addr_i[14 * 7 +: 7] = 7'h50;
        sw_addr_i[15 * 7 +: 7] = 7'h78;
        repeat (30) begin
            s = $urandom_range(9, 0);
            slow = $urandom;
            o = $urandom_range(sw_type_i[s] ? 1 : 3, 0);
            if (s < 8) begin
                acc(0, 0, 16'hf000 + 16'(4 * s + o), '0);
                chk("var dig", {8'h00, pat(s, o)}, rd);
            end else begin
                s = s + 6;
                o = 2 * $urandom_range(s == 14 ? 15 : 7, 0);
                acc(0, 1, 16'(s == 14 ? 16'hf0a0 : 16'hf0f0) + 16'(o), '0);
                chk("var ana", {pat(s, o), pat(s, o + 1)}, rd);
            end
        end
        acc(1, 0, 16'hf000, 16'h005a);
        chk("shared out", 16'h005a, iosd_mods_i.mem[13][0]);
        acc(0, 0, 16'hf000, '0);
        chk("shared in", {8'h00, pat(0, 0)}, rd);
        print_verdict;
    end
endmodule
